// ==== design/fbd_pkg.sv ====
package fbd_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned SETTLE_MS  = 100;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);

  // ==========================================
  // command word values and bits
  localparam logic [15:0] CMD_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CMD_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CMD_ENABLE   = 16'h000F;
  localparam logic [15:0] CMD_RAMP_REL = 16'h002F;
  localparam logic [15:0] CMD_RUN      = 16'h006F;
  localparam int unsigned CMD_FLT_RST_BIT = 7;

  // ==========================================
  // setpoint scaling
  localparam logic [15:0] SP1_FULL  = 16'h4E20;
  localparam logic [15:0] SP2_FULL  = 16'h2710;
  localparam logic [31:0] PCT_FULL  = 32'h0000_2710;
  localparam logic [31:0] REL_FULL  = 32'h0000_03E8;
  localparam logic [15:0] SP_MAG_MAX = 16'h7FFF;

  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_STAT    = 8'h04;
  localparam logic [7:0] OFS_SP1     = 8'h08;
  localparam logic [7:0] OFS_SP2     = 8'h0C;
  localparam logic [7:0] OFS_SP1_LIM = 8'h10;
  localparam logic [7:0] OFS_SP2_LIM = 8'h14;
  localparam logic [7:0] OFS_FINAL   = 8'h18;
  localparam logic [7:0] OFS_CFG     = 8'h1C;
  localparam logic [7:0] OFS_REL_SPD = 8'h20;
  localparam logic [7:0] OFS_AI_WARN = 8'h24;
  localparam logic [7:0] OFS_AI_ALRM = 8'h28;
  localparam logic [7:0] OFS_AI_CFG  = 8'h2C;
  localparam logic [7:0] OFS_AI_OVR  = 8'h30;
  localparam logic [7:0] OFS_BI_CFG  = 8'h34;
  localparam logic [7:0] OFS_PT_STAT = 8'h38;
  localparam logic [7:0] OFS_AO      = 8'h3C;
  localparam logic [7:0] OFS_AO_OVR  = 8'h40;
  localparam logic [7:0] OFS_BO      = 8'h44;
  localparam logic [7:0] OFS_BO_OVR  = 8'h48;
  localparam logic [7:0] OFS_DEVTYPE = 8'h4C;
  localparam logic [7:0] OFS_REL_MAX = 8'h50;

  // ==========================================
  // reset values
  localparam logic [31:0] RST_LIM     = 32'h2710_D8F0;
  localparam logic [2:0]  RST_CFG     = 3'h3;
  localparam logic [31:0] RST_AI_WARN = 32'h2328_03E8;
  localparam logic [31:0] RST_AI_ALRM = 32'h2710_0000;
  localparam logic [31:0] RST_REL_MAX = 32'h05DC_01F4;

  // ==========================================
  // types
  typedef enum logic [2:0] {
    ST_NOT_RDY   = 3'h0,
    ST_RDY_ON    = 3'h1,
    ST_RDY_OP    = 3'h3,
    ST_OP_EN     = 3'h2,
    ST_ACC_EN    = 3'h6,
    ST_OPERATING = 3'h7,
    ST_FAULT     = 3'h5
  } fbd_state_t;

  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
  } fbd_lim_t;

  typedef struct packed {
    logic hi_alarm;
    logic hi_warn;
    logic lo_warn;
    logic lo_alarm;
  } fbd_ai_flag_t;
endpackage

// ==== design/fbd_drive_ctrl.sv ====
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - reset enters not-ready-to-switch-on state
// - command 0006 gives ready-to-switch-on
// - command 0007 gives ready-to-operate
// - command 000F enables operation, holds speed
// - command 002F releases ramp generator output
// - command 006F runs, follows the setpoint
// - external fault reset acts like bus reset
// - primary setpoint 20000 is 100 percent
// - secondary setpoint 10000 is 100 percent
// - floor settings never change setpoint scaling
// - setpoints signed, direction settings gate sign
// - only analog/binary points, no internal values
// - analog alarms, warnings with hysteresis differential
// - binary normal state, alarm, change reporting
// - input point override accepted, ignored
// - output override overwrites, release keeps value
// - relative speed uses frequency or speed base
// - fixed three-character device type code
module fbd_drive_ctrl
  import fbd_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_P = SETTLE_CYC,
  parameter logic [23:0] DEV_TYPE     = 24'h41_4141  // arbitrary code
) (
  input  wire logic               clk_sys_in,          // system clock
  input  wire logic               rst_n_in,            // sync reset, low
  input  wire logic [7:0]         avs_address_in,      // byte address
  input  wire logic               avs_read_in,         // read request
  input  wire logic               avs_write_in,        // write request
  input  wire logic [31:0]        avs_writedata_in,    // write data
  input  wire logic [3:0]         avs_byteenable_in,   // byte lanes
  output logic      [31:0]        avs_readdata_out,    // read data
  output logic                    avs_waitrequest_out, // stall
  input  wire logic               fault_in,            // drive fault
  input  wire logic               fault_reset_ext_in,  // other reset source
  input  wire logic signed [15:0] ai_value_in,         // analog point value
  input  wire logic               bi_value_in,         // binary point value
  input  wire logic [15:0]        freq_act_in,         // actual frequency
  input  wire logic [15:0]        speed_act_in,        // actual speed
  output fbd_state_t              state_out,           // control state
  output logic                    modulate_out,        // power stage on
  output logic                    ramp_release_out,    // ramp output free
  output logic                    ramp_follow_out,     // ramp tracks input
  output logic signed [15:0]      sp1_final_out,       // primary, 0.01 %
  output logic signed [15:0]      sp2_final_out,       // secondary, 0.01 %
  output logic [15:0]             ao_value_out,        // analog out point
  output logic                    bo_value_out         // binary out point
);

  // ==========================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction
  // signed count to 0.01 % of full scale, negative mirrored
  function automatic logic signed [15:0] scale(input logic signed [15:0] sp,
                                               input logic [15:0]        full);
    logic [15:0] mag;
    logic [31:0] q;
    mag = sp[15] ? 16'(-sp) : 16'(sp);
    if (mag > SP_MAG_MAX) mag = SP_MAG_MAX;
    q = ({16'h0000, mag} * PCT_FULL) / {16'h0000, full};
    return sp[15] ? $signed(-q[15:0]) : $signed(q[15:0]);
  endfunction
  // direction gate then limit clamp
  function automatic logic signed [15:0] bound(input logic signed [15:0] s,
                                               input fbd_lim_t           lim,
                                               input logic               fwd,
                                               input logic               rev);
    logic signed [15:0] v;
    v = s;
    if ((!fwd && v > 0) || (!rev && v < 0)) v = '0;
    if (v > lim.hi) v = lim.hi;
    if (v < lim.lo) v = lim.lo;
    return v;
  endfunction
  // threshold with hysteresis band
  function automatic logic hyst(input logic               cur,
                                input logic signed [15:0] v,
                                input logic signed [15:0] lim,
                                input logic [15:0]        d,
                                input logic               up);
    logic signed [17:0] vv;
    logic signed [17:0] th;
    logic signed [17:0] dd;
    vv = 18'(v);
    th = 18'(lim);
    dd = $signed({2'b00, d});
    if (up) begin
      return cur ? (vv >= th - dd) : (vv > th);
    end
    return cur ? (vv <= th + dd) : (vv < th);
  endfunction

  // ==========================================
  // registers
  logic               ack_r;
  logic [31:0]        rdata_r;
  logic [31:0]        rd_nxt;
  logic               wr_fire;
  logic [31:0]        wd;
  logic [15:0]        cmd_r;
  logic               flt_rst_bit_r;
  logic               ext_rst_r;
  logic               flt_rst;
  fbd_state_t         state_r;
  fbd_state_t         state_nxt;
  logic [23:0]        settle_cnt_r;
  logic               settle_done_r;
  logic signed [15:0] sp1_r;
  logic signed [15:0] sp2_r;
  fbd_lim_t           sp1_lim_r;
  fbd_lim_t           sp2_lim_r;
  logic [2:0]         cfg_r;
  logic [31:0]        rel_max_r;
  logic [15:0]        rel_spd_r;
  logic [31:0]        rel_num;
  logic [15:0]        rel_den;
  fbd_lim_t           ai_warn_r;
  fbd_lim_t           ai_alrm_r;
  logic [18:0]        ai_cfg_r;
  fbd_ai_flag_t       ai_raw_r;
  fbd_ai_flag_t       ai_flag;
  fbd_ai_flag_t       ai_flag_d_r;
  logic [2:0]         bi_cfg_r;
  logic               bi_d_r;
  logic               bi_alarm;
  logic               ai_cos_r;
  logic               bi_cos_r;
  logic [15:0]        ao_r;
  logic               bo_r;

  // ==========================================
  // avalon slave: one wait cycle, then answer
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign avs_readdata_out    = rdata_r;
  assign wr_fire             = avs_write_in & ack_r;
  assign wd                  = avs_writedata_in;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (avs_address_in)
      OFS_CMD:     rd_nxt = {16'h0000, cmd_r};
      OFS_STAT:    rd_nxt = {24'h00_0000, settle_done_r, ramp_follow_out,
                             ramp_release_out, modulate_out,
                             state_r == ST_FAULT, state_r};
      OFS_SP1:     rd_nxt = {16'h0000, sp1_r};
      OFS_SP2:     rd_nxt = {16'h0000, sp2_r};
      OFS_SP1_LIM: rd_nxt = sp1_lim_r;
      OFS_SP2_LIM: rd_nxt = sp2_lim_r;
      OFS_FINAL:   rd_nxt = {sp2_final_out, sp1_final_out};
      OFS_CFG:     rd_nxt = {29'h0000_0000, cfg_r};
      OFS_REL_SPD: rd_nxt = {16'h0000, rel_spd_r};
      OFS_AI_WARN: rd_nxt = ai_warn_r;
      OFS_AI_ALRM: rd_nxt = ai_alrm_r;
      OFS_AI_CFG:  rd_nxt = {13'h0000, ai_cfg_r};
      OFS_BI_CFG:  rd_nxt = {29'h0000_0000, bi_cfg_r};
      OFS_PT_STAT: rd_nxt = {25'h000_0000, bi_cos_r, ai_cos_r, bi_alarm,
                             ai_flag};
      OFS_AO:      rd_nxt = {16'h0000, ao_r};
      OFS_BO:      rd_nxt = {31'h0000_0000, bo_r};
      OFS_DEVTYPE: rd_nxt = {8'h00, DEV_TYPE};
      OFS_REL_MAX: rd_nxt = rel_max_r;
      default:     rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else if (avs_read_in && !ack_r) begin
      rdata_r <= rd_nxt;
    end
  end

  // ==========================================
  // command word and fault reset sources
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmd_r <= '0;
    end else if (wr_fire && avs_address_in == OFS_CMD) begin
      cmd_r <= 16'(merge({16'h0000, cmd_r}, wd, avs_byteenable_in));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      flt_rst_bit_r <= 1'b0;
      ext_rst_r     <= 1'b0;
    end else begin
      flt_rst_bit_r <= cmd_r[CMD_FLT_RST_BIT];
      ext_rst_r     <= fault_reset_ext_in;
    end
  end
  assign flt_rst = (cmd_r[CMD_FLT_RST_BIT] & ~flt_rst_bit_r)
                 | (fault_reset_ext_in & ~ext_rst_r);

  // ==========================================
  // control state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FAULT:     if (flt_rst) state_nxt = ST_NOT_RDY;
      ST_NOT_RDY:   if (cmd_r == CMD_SHUTDOWN) state_nxt = ST_RDY_ON;
      ST_RDY_ON:    if (cmd_r == CMD_SWITCH_ON) state_nxt = ST_RDY_OP;
      ST_RDY_OP:    if (cmd_r == CMD_ENABLE) state_nxt = ST_OP_EN;
      ST_OP_EN:     if (cmd_r == CMD_RAMP_REL) state_nxt = ST_ACC_EN;
      ST_ACC_EN:    if (cmd_r == CMD_RUN) state_nxt = ST_OPERATING;
      ST_OPERATING: state_nxt = ST_OPERATING;
      default:      state_nxt = ST_NOT_RDY;
    endcase
    // shutdown word drops any running state back to ready-on
    if (state_r != ST_FAULT && state_r != ST_NOT_RDY &&
        cmd_r == CMD_SHUTDOWN) begin
      state_nxt = ST_RDY_ON;
    end
    if (fault_in) state_nxt = ST_FAULT;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= ST_NOT_RDY;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign state_out        = state_r;
  assign modulate_out     = state_r == ST_OP_EN || state_r == ST_ACC_EN ||
                            state_r == ST_OPERATING;
  assign ramp_release_out = state_r == ST_ACC_EN ||
                            state_r == ST_OPERATING;
  assign ramp_follow_out  = state_r == ST_OPERATING;

  // settle time after ready-on, reported only
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || state_r != ST_RDY_ON) begin
      settle_cnt_r  <= '0;
      settle_done_r <= 1'b0;
    end else if (settle_cnt_r >= 24'(SETTLE_CYC_P - 1)) begin
      settle_done_r <= 1'b1;
    end else begin
      settle_cnt_r <= settle_cnt_r + 24'h00_0001;
    end
  end

  // ==========================================
  // setpoints: scale, direction, clamp
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sp1_r     <= '0;
      sp2_r     <= '0;
      sp1_lim_r <= RST_LIM;
      sp2_lim_r <= RST_LIM;
      cfg_r     <= RST_CFG;
      rel_max_r <= RST_REL_MAX;
    end else if (wr_fire) begin
      case (avs_address_in)
        OFS_SP1:     sp1_r     <= 16'(merge(32'(sp1_r), wd, avs_byteenable_in));
        OFS_SP2:     sp2_r     <= 16'(merge(32'(sp2_r), wd, avs_byteenable_in));
        OFS_SP1_LIM: sp1_lim_r <= merge(sp1_lim_r, wd, avs_byteenable_in);
        OFS_SP2_LIM: sp2_lim_r <= merge(sp2_lim_r, wd, avs_byteenable_in);
        OFS_CFG:     cfg_r     <= wd[2:0];
        OFS_REL_MAX: rel_max_r <= merge(rel_max_r, wd, avs_byteenable_in);
        default:     cfg_r     <= cfg_r;
      endcase
    end
  end

  // floors enter only the clamp, never the scale
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sp1_final_out <= '0;
      sp2_final_out <= '0;
    end else begin
      sp1_final_out <= bound(scale(sp1_r, SP1_FULL), sp1_lim_r,
                             cfg_r[0], cfg_r[1]);
      sp2_final_out <= bound(scale(sp2_r, SP2_FULL), sp2_lim_r,
                             cfg_r[0], cfg_r[1]);
    end
  end

  // ==========================================
  // relative speed point, 0.1 % units
  assign rel_num = cfg_r[2] ? {16'h0000, speed_act_in} : {16'h0000, freq_act_in};
  assign rel_den = cfg_r[2] ? rel_max_r[31:16] : rel_max_r[15:0];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || rel_den == 16'h0000) begin
      rel_spd_r <= '0;
    end else begin
      rel_spd_r <= 16'((rel_num * REL_FULL) / {16'h0000, rel_den});
    end
  end
  // ==========================================
  // input points; override writes land nowhere
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ai_warn_r <= RST_AI_WARN;
      ai_alrm_r <= RST_AI_ALRM;
      ai_cfg_r  <= '0;
      bi_cfg_r  <= '0;
    end else if (wr_fire) begin
      case (avs_address_in)
        OFS_AI_WARN: ai_warn_r <= merge(ai_warn_r, wd, avs_byteenable_in);
        OFS_AI_ALRM: ai_alrm_r <= merge(ai_alrm_r, wd, avs_byteenable_in);
        OFS_AI_CFG:  ai_cfg_r  <= wd[18:0];
        OFS_BI_CFG:  bi_cfg_r  <= wd[2:0];
        OFS_AI_OVR:  bi_cfg_r  <= bi_cfg_r;
        default:     bi_cfg_r  <= bi_cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ai_raw_r <= '0;
    end else begin
      ai_raw_r.hi_alarm <= hyst(ai_raw_r.hi_alarm, ai_value_in, ai_alrm_r.hi,
                                ai_cfg_r[15:0], 1'b1);
      ai_raw_r.hi_warn  <= hyst(ai_raw_r.hi_warn, ai_value_in, ai_warn_r.hi,
                                ai_cfg_r[15:0], 1'b1);
      ai_raw_r.lo_warn  <= hyst(ai_raw_r.lo_warn, ai_value_in, ai_warn_r.lo,
                                ai_cfg_r[15:0], 1'b0);
      ai_raw_r.lo_alarm <= hyst(ai_raw_r.lo_alarm, ai_value_in, ai_alrm_r.lo,
                                ai_cfg_r[15:0], 1'b0);
    end
  end

  always_comb begin
    ai_flag          = ai_raw_r;
    ai_flag.hi_alarm = ai_raw_r.hi_alarm & ai_cfg_r[16];
    ai_flag.lo_alarm = ai_raw_r.lo_alarm & ai_cfg_r[16];
    ai_flag.hi_warn  = ai_raw_r.hi_warn & ai_cfg_r[17];
    ai_flag.lo_warn  = ai_raw_r.lo_warn & ai_cfg_r[17];
  end

  assign bi_alarm = bi_cfg_r[1] & (bi_value_in != bi_cfg_r[0]);

  // change events are sticky, write one to clear, set wins
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ai_flag_d_r <= '0;
      bi_d_r      <= 1'b0;
      ai_cos_r    <= 1'b0;
      bi_cos_r    <= 1'b0;
    end else begin
      ai_flag_d_r <= ai_flag;
      bi_d_r      <= bi_value_in;
      if (ai_cfg_r[18] && ai_flag != ai_flag_d_r) begin
        ai_cos_r <= 1'b1;
      end else if (wr_fire && avs_address_in == OFS_PT_STAT && wd[5]) begin
        ai_cos_r <= 1'b0;
      end
      if (bi_cfg_r[2] && bi_value_in != bi_d_r) begin
        bi_cos_r <= 1'b1;
      end else if (wr_fire && avs_address_in == OFS_PT_STAT && wd[6]) begin
        bi_cos_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // output points; override replaces value for good
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ao_r <= '0;
      bo_r <= 1'b0;
    end else if (wr_fire) begin
      case (avs_address_in)
        OFS_AO, OFS_AO_OVR: ao_r <= 16'(merge({16'h0000, ao_r}, wd, avs_byteenable_in));
        OFS_BO, OFS_BO_OVR: bo_r <= wd[0];
        default:            bo_r <= bo_r;
      endcase
    end
  end

  assign ao_value_out = ao_r;
  assign bo_value_out = bo_r;

endmodule

// ==== dv/fbd_drive_ctrl_props.sv ====
`timescale 1ns/1ps
module fbd_drive_ctrl_props
  import fbd_pkg::*;
(
  input wire logic        clk_sys_in,          // clock
  input wire logic        rst_n_in,            // reset
  input wire logic [7:0]  avs_address_in,      // address
  input wire logic        avs_read_in,         // read
  input wire logic        avs_write_in,        // write
  input wire logic [31:0] avs_writedata_in,    // data
  input wire logic        avs_waitrequest_out, // stall
  input wire logic        fault_in,            // fault
  input wire logic        fault_reset_ext_in,  // ext reset
  input wire fbd_state_t  state_out,           // state
  input wire logic        modulate_out,        // modulating
  input wire logic        ramp_release_out,    // ramp free
  input wire logic        ramp_follow_out      // follow
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // sequences
  sequence s_enter(fbd_state_t st);
    $changed(state_out) && state_out == st;
  endsequence
  sequence s_cmd(logic [15:0] c);
    avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CMD && avs_writedata_in[15:0] == c
      && !fault_in && state_out != ST_FAULT;
  endsequence
  property p_from(fbd_state_t st, fbd_state_t prev);
    s_enter(st) |-> $past(state_out) == prev;
  endproperty
  // ==========================================
  // assertions
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait not one cycle");
  a_reset_state: assert property ($rose(rst_n_in) |-> state_out == ST_NOT_RDY)
    else $error("not in start state");
  a_cmd_ready: assert property (s_cmd(CMD_SHUTDOWN) |-> ##[1:2] state_out == ST_RDY_ON)
    else $error("shutdown ignored");
  a_enter_rdy_op: assert property (p_from(ST_RDY_OP, ST_RDY_ON))
    else $error("bad entry ready op");
  a_enter_op_en: assert property (p_from(ST_OP_EN, ST_RDY_OP))
    else $error("bad entry op enabled");
  a_enter_acc_en: assert property (p_from(ST_ACC_EN, ST_OP_EN))
    else $error("bad entry acc enabled");
  a_enter_running: assert property (p_from(ST_OPERATING, ST_ACC_EN))
    else $error("bad entry operating");
  a_fault_entry: assert property (fault_in |=> state_out == ST_FAULT)
    else $error("fault not entered");
  a_fault_exit: assert property (state_out == ST_FAULT && !fault_in && $rose(fault_reset_ext_in)
    |-> ##[1:2] state_out == ST_NOT_RDY)
    else $error("ext reset ignored");
  a_mod_decode: assert property (modulate_out == (state_out inside {ST_OP_EN, ST_ACC_EN, ST_OPERATING}))
    else $error("modulate mismatch");
  a_ramp_decode: assert property ({ramp_release_out, ramp_follow_out} ==
    {state_out inside {ST_ACC_EN, ST_OPERATING}, state_out == ST_OPERATING})
    else $error("ramp mismatch");
endmodule

bind fbd_drive_ctrl fbd_drive_ctrl_props u_props (.clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .fault_in, .fault_reset_ext_in, .state_out,
  .modulate_out, .ramp_release_out, .ramp_follow_out);

// ==== dv/fbd_bus_master.sv ====
`timescale 1ns/1ps
module fbd_bus_master
#(
  parameter int unsigned SETTLE_CYC_P = 20
) (
  input  wire logic        clk_sys_in,         // clock
  input  wire logic        avs_waitrequest_in, // stall
  output logic [7:0]       avs_address_out,    // address
  output logic             avs_read_out,       // read
  output logic             avs_write_out,      // write
  output logic [31:0]      avs_writedata_out,  // data
  output logic [3:0]       avs_byteenable_out  // lanes
);
  initial begin
    avs_address_out = 8'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h0000_0000;
    avs_byteenable_out = 4'hF;
  end
  // one transfer, held until stall drops
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_out <= a;
    avs_write_out <= wr_en;
    avs_read_out <= !wr_en;
    avs_writedata_out <= d;
    @(posedge clk_sys_in);
    while (avs_waitrequest_in !== 1'b0) @(posedge clk_sys_in);
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
  endtask
  // pause after reaching ready-on
  task automatic settle;
    repeat (SETTLE_CYC_P) @(posedge clk_sys_in);
  endtask
endmodule

// ==== dv/fbd_drive_command_state_test.sv ====
`timescale 1ns/1ps
module fbd_drive_command_state_test
  import fbd_pkg::*;
;
  localparam logic [23:0] DEVT = 24'h5A_5A5A; // arbitrary code
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, avs_read_in, avs_write_in, avs_waitrequest_out, fault_in = 1'b0;
  logic fault_reset_ext_in = 1'b0, bi_value_in = 1'b0, modulate_out, ramp_release_out, ramp_follow_out, bo_value_out;
  logic [7:0] avs_address_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic signed [15:0] ai_value_in = 16'sh0000, sp1_final_out, sp2_final_out;
  logic [15:0] freq_act_in = 16'h0000, speed_act_in = 16'h0000, ao_value_out;
  fbd_state_t state_out;
  int mismatches = 0, samples_checked = 0, seed = 32'h1def, sv, e;
  logic [63:0] q[$];
  logic [71:0] rst_tab [9] = '{{OFS_STAT, 32'h0, 32'h7F}, {OFS_SP1_LIM, RST_LIM, 32'hFFFF_FFFF},
    {OFS_SP2_LIM, RST_LIM, 32'hFFFF_FFFF}, {OFS_AI_WARN, RST_AI_WARN, 32'hFFFF_FFFF},
    {OFS_AI_ALRM, RST_AI_ALRM, 32'hFFFF_FFFF}, {OFS_REL_MAX, RST_REL_MAX, 32'hFFFF_FFFF},
    {OFS_CFG, {29'h0, RST_CFG}, 32'h7}, {8'hFC, 32'h0, 32'hFFFF_FFFF}, {OFS_DEVTYPE, {8'h0, DEVT}, 32'hFFFF_FFFF}};
  logic [15:0] cmd_tab [5] = '{CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_ENABLE, CMD_RAMP_REL, CMD_RUN};
  logic [7:0] stat_tab [5] = '{8'h01, 8'h03, 8'h12, 8'h36, 8'h77};
  logic [15:0] ai_tab [5] = '{16'd12000, 16'd9950, 16'd9800, 16'd8000, 16'hFFFB};
  logic [3:0] flg_tab [5] = '{4'hC, 4'hC, 4'h4, 4'h0, 4'h3};
  always #50 clk_sys_in = ~clk_sys_in;
  fbd_drive_ctrl #(.SETTLE_CYC_P(20), .DEV_TYPE(DEVT)) dut (.clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .fault_in,
    .fault_reset_ext_in, .ai_value_in, .bi_value_in, .freq_act_in, .speed_act_in, .state_out, .modulate_out,
    .ramp_release_out, .ramp_follow_out, .sp1_final_out, .sp2_final_out, .ao_value_out, .bo_value_out);
  fbd_bus_master #(.SETTLE_CYC_P(20)) u_m (.clk_sys_in, .avs_waitrequest_in(avs_waitrequest_out),
    .avs_address_out(avs_address_in), .avs_read_out(avs_read_in), .avs_write_out(avs_write_in),
    .avs_writedata_out(avs_writedata_in), .avs_byteenable_out(avs_byteenable_in));
  // ==========================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_m.xfer(1'b1, a, d);
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    q.push_back({x, m});
    u_m.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [63:0] n);
    samples_checked++;
    if (((got ^ n[63:32]) & n[31:0]) !== 32'h0000_0000) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, n[63:32]);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // monitor and watchdog
  always @(posedge clk_sys_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && q.size() != 0) cmp(avs_readdata_out, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    $display("CHECK FAILED t=%0t timeout", $time);
    finish_test();
  end

  // ==========================================
  // tests
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (rst_tab[i]) chk(rst_tab[i][71:64], rst_tab[i][63:32], rst_tab[i][31:0]);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CMD, {16'h0000, cmd_tab[i]});
      if (i == 0) begin
        u_m.settle();
        wr(OFS_CMD, {16'h0000, CMD_ENABLE});
        chk(OFS_STAT, 32'h01, 32'h7F);
      end
      chk(OFS_STAT, {24'h0, stat_tab[i]}, 32'h7F);
    end
    fault_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk(OFS_STAT, 32'h0D, 32'h0F);
    fault_in <= 1'b0;
    fault_reset_ext_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk(OFS_STAT, 32'h00, 32'h7F);
    fault_reset_ext_in <= 1'b0;
    fault_in <= 1'b1;
    @(posedge clk_sys_in);
    fault_in <= 1'b0;
    wr(OFS_CMD, 32'h0000_0080);
    chk(OFS_STAT, 32'h00, 32'h7F);
    $display("test states done");
    for (int i = 0; i < 4; i++) begin
      sv = $random(seed) % 32768;
      wr(OFS_SP1, {16'h0000, sv[15:0]});
      e = sv / 2;
      e = (e > 10000) ? 10000 : (e < -10000) ? -10000 : e;
      chk(OFS_FINAL, {16'h0000, e[15:0]}, 32'h0000_FFFF);
    end
    wr(OFS_SP1_LIM, 32'h2710_03E8);
    wr(OFS_SP1, 32'h0000_0FA0);
    chk(OFS_FINAL, 32'h0000_07D0, 32'h0000_FFFF);
    wr(OFS_SP2, 32'h0000_1388);
    chk(OFS_FINAL, 32'h1388_0000, 32'hFFFF_0000);
    wr(OFS_SP2_LIM, 32'h0BB8_F448);
    chk(OFS_FINAL, 32'h0BB8_0000, 32'hFFFF_0000);
    wr(OFS_SP2, 32'h0000_F060);
    chk(OFS_FINAL, 32'hF448_0000, 32'hFFFF_0000);
    wr(OFS_CFG, 32'h0000_0001);
    chk(OFS_FINAL, 32'h0000_0000, 32'hFFFF_0000);
    $display("test setpoints done");
    wr(OFS_AI_CFG, 32'h0007_0064);
    for (int i = 0; i < 5; i++) begin
      ai_value_in <= ai_tab[i];
      repeat (2) @(posedge clk_sys_in);
      chk(OFS_PT_STAT, {28'h0, flg_tab[i]}, 32'h0F);
    end
    wr(OFS_AI_OVR, 32'h0000_7FFF);
    chk(OFS_PT_STAT, 32'h03, 32'h0F);
    wr(OFS_BI_CFG, 32'h0000_0006);
    bi_value_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk(OFS_PT_STAT, 32'h70, 32'h70);
    wr(OFS_PT_STAT, 32'h0000_0060);
    chk(OFS_PT_STAT, 32'h10, 32'h70);
    wr(OFS_AO, 32'h0000_1234);
    wr(OFS_AO_OVR, 32'h0000_0555);
    chk(OFS_AO, 32'h0000_0555, 32'h0000_FFFF);
    wr(OFS_BO_OVR, 32'h0000_0001);
    chk(OFS_BO, 32'h0000_0001, 32'h0000_0001);
    cmp({15'h0000, bo_value_out, ao_value_out}, {32'h0001_0555, 32'h0001_FFFF});
    $display("test points done");
    freq_act_in <= 16'd250;
    speed_act_in <= 16'd300;
    repeat (2) @(posedge clk_sys_in);
    chk(OFS_REL_SPD, 32'h0000_01F4, 32'h0000_FFFF);
    wr(OFS_CFG, 32'h0000_0007);
    chk(OFS_REL_SPD, 32'h0000_00C8, 32'h0000_FFFF);
    $display("test speed done");
    repeat (3) @(posedge clk_sys_in);
    finish_test();
  end
endmodule
